// >>> hdl/upc_defs.vh
`ifndef UPC_DEFS_VH
`define UPC_DEFS_VH
`define UPC_PHY_BASE          12'h200
`define UPC_OFF_COMMON_TEST   12'h000
`define UPC_OFF_FE_TEST       12'h0C4
`define UPC_OFF_FE_UPSTREAM   12'h0C8
`define UPC_WINDOW_LAST       12'h13C
`define UPC_BIT_CLOCK_OFF     31
`define UPC_BIT_SIG_SELECT    24
`define UPC_BIT_XTAL_GAIN     23
`define UPC_BIT_REF_SELECT    19
`define UPC_BIT_CORE_READY    18
`define UPC_BIT_FAST_START    17
`define UPC_BIT_PLL_ENABLE    16
`define UPC_BIT_COMMON_SUSP_N 15
`define UPC_BIT_XTAL_SUSP_N   14
`define UPC_BIT_PLL_CLK_OK    12
`define UPC_BIT_SS_PLL_ENABLE 11
`define UPC_BIT_SS_CLK_OK     10
`define UPC_BIT_TIMER_OFF     9
`define UPC_BIT_GATE_BYPASS   0
`define UPC_WRITE_MASK        32'h818BCA01
`define UPC_SYNC_STAGES       3
`define UPC_RESET_VALUE       32'h00010000
`endif

// >>> hdl/upc_common_test_regs.v
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "upc_defs.vh"
module upc_common_test_regs
(
  input  wire        clock,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        eepromPresent,
  input  wire        eepromFastStartHs,
  input  wire        eepromFastStartFs,
  input  wire        highSpeedMode,
  input  wire        otpConfigured,
  input  wire        otpFastStart,
  input  wire        usbReset,
  input  wire        liteReset,
  input  wire        coreSupplyReady,
  input  wire        ioSupplyReady,
  input  wire        pllClockUsable,
  input  wire        ssClockUsable,
  input  wire [31:0] frontendTestIn,
  input  wire [31:0] frontendUpstreamIn,
  output reg         commonClockGateOff,
  output reg         commonTestSignalSelect,
  output reg         crystalGainSelect,
  output reg         pllReferenceSelect,
  output reg         pllFastStartEnable,
  output reg         usb2PllEnable,
  output reg         commonSuspend_n,
  output reg         crystalSuspend_n,
  output reg         superspeedTxPllEnable,
  output reg         frontendReadyTimerOff,
  output reg         globalGatingBypass,
  output reg         frontendTestWrite,
  output reg         frontendUpstreamWrite,
  output reg  [31:0] frontendWriteData
);
  reg  [31:0] ctl_q;
  reg  [31:0] ctl_d;
  reg         imageFast_q;
  reg         loaded_q;
  // one-hot answer states
  localparam [1:0] ST_IDLE   = 2'h1;
  localparam [1:0] ST_ANSWER = 2'h2;
  reg  [31:0] readWord;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  wire        coreOk;
  wire        ioOk;
  wire        pllOk;
  wire        ssOk;
  wire        usbRise;
  wire        liteRise;
  wire [31:0] storeMask;
  wire        imageFast;
  wire        fastReload;
  wire        access;
  wire        writeTaken;
  wire        hitCommon;
  wire        hitFeTest;
  wire        hitFeUp;
  wire        inWindow;
  wire [11:0] offset;
  wire [31:0] byteMask;
  wire [31:0] statusBits;

  // image source priority: eeprom, then otp, then zero
  assign imageFast = eepromPresent ? (highSpeedMode ? eepromFastStartHs : eepromFastStartFs)
                   : (otpConfigured ? otpFastStart : 1'b0);
  // rising edge of either reset request reloads the image
  assign fastReload = usbRise | liteRise;

  assign offset    = paddr - `UPC_PHY_BASE;
  assign inWindow  = (paddr >= `UPC_PHY_BASE) && (offset <= `UPC_WINDOW_LAST);
  assign hitCommon = inWindow && (offset == `UPC_OFF_COMMON_TEST);
  assign hitFeTest = inWindow && (offset == `UPC_OFF_FE_TEST);
  assign hitFeUp   = inWindow && (offset == `UPC_OFF_FE_UPSTREAM);
  assign access     = psel & penable & (state_q == ST_IDLE);
  assign writeTaken = access & pwrite;
  assign byteMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign storeMask = byteMask & `UPC_WRITE_MASK;

  // core ready forced low unless io supply is up
  assign statusBits = ({31'h0, coreOk & ioOk} << `UPC_BIT_CORE_READY)
                    | ({31'h0, pllOk} << `UPC_BIT_PLL_CLK_OK)
                    | ({31'h0, ssOk} << `UPC_BIT_SS_CLK_OK);

  always @*
  begin
    ctl_d = ctl_q;
    if (!loaded_q)
    begin
      // first clock after reset: image lands in the fast-start bit
      ctl_d[`UPC_BIT_FAST_START] = imageFast;
    end
    else
    begin
      if (writeTaken && hitCommon)
      begin
        // reserved and read-only bits never stored
        ctl_d = (ctl_q & ~storeMask) | (pwdata & storeMask);
      end
      if (fastReload)
      begin
        // reload wins over a same-cycle write of the bit
        ctl_d[`UPC_BIT_FAST_START] = imageFast_q;
      end
    end
  end

  // three-stage sync; second and third must agree before a change counts
  upc_sync3 u_coreSync
  (
    .clock     (clock),
    .reset     (reset),
    .pinIn     (coreSupplyReady),
    .syncLevel (coreOk),
    .syncRise  ()
  );

  upc_sync3 u_ioSync
  (
    .clock     (clock),
    .reset     (reset),
    .pinIn     (ioSupplyReady),
    .syncLevel (ioOk),
    .syncRise  ()
  );

  upc_sync3 u_pllSync
  (
    .clock     (clock),
    .reset     (reset),
    .pinIn     (pllClockUsable),
    .syncLevel (pllOk),
    .syncRise  ()
  );

  upc_sync3 u_ssSync
  (
    .clock     (clock),
    .reset     (reset),
    .pinIn     (ssClockUsable),
    .syncLevel (ssOk),
    .syncRise  ()
  );

  upc_sync3 u_usbRstSync
  (
    .clock     (clock),
    .reset     (reset),
    .pinIn     (usbReset),
    .syncLevel (),
    .syncRise  (usbRise)
  );

  upc_sync3 u_liteRstSync
  (
    .clock     (clock),
    .reset     (reset),
    .pinIn     (liteReset),
    .syncLevel (),
    .syncRise  (liteRise)
  );

  // image caught on the first clock after reset release, not in reset itself
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      imageFast_q <= 1'b0;
      loaded_q    <= 1'b0;
    end
    else if (!loaded_q)
    begin
      imageFast_q <= imageFast;
      loaded_q    <= 1'b1;
    end
  end

  // control word; out of reset only the PLL enable is set
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ctl_q <= `UPC_RESET_VALUE;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  // answer sequencer: exactly one wait state, then a one-cycle ready
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (psel && penable)
        begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        // stray code recovers to idle rather than locking the bus
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // read word by decoded register; anything else reads zero
  always @*
  begin
    readWord = 32'h00000000;
    case (1'b1)
      hitCommon:
      begin
        readWord = (ctl_q & `UPC_WRITE_MASK) | statusBits;
      end
      hitFeTest:
      begin
        readWord = frontendTestIn;
      end
      hitFeUp:
      begin
        readWord = frontendUpstreamIn;
      end
      default:
      begin
        readWord = 32'h00000000;
      end
    endcase
  end

  // one wait state: ready in the second access cycle
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      prdata                <= 32'h0;
      frontendTestWrite     <= 1'b0;
      frontendUpstreamWrite <= 1'b0;
      frontendWriteData     <= 32'h0;
    end
    else
    begin
      pready                <= access;
      pslverr               <= 1'b0;
      frontendTestWrite     <= writeTaken & hitFeTest;
      frontendUpstreamWrite <= writeTaken & hitFeUp;
      frontendWriteData     <= pwdata;
      prdata                <= 32'h0;
      if (access)
      begin
        // reserved gaps and outside window: error, write dropped
        pslverr <= ~(hitCommon | hitFeTest | hitFeUp);
        if (!pwrite)
        begin
          prdata <= readWord;
        end
      end
    end
  end

  // field outputs, registered from the control word
  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      commonClockGateOff     <= 1'b0;
      commonTestSignalSelect <= 1'b0;
      crystalGainSelect      <= 1'b0;
      pllReferenceSelect     <= 1'b0;
      pllFastStartEnable     <= 1'b0;
      usb2PllEnable          <= 1'b1;
      commonSuspend_n        <= 1'b0;
      crystalSuspend_n       <= 1'b0;
      superspeedTxPllEnable  <= 1'b0;
      frontendReadyTimerOff  <= 1'b0;
      globalGatingBypass     <= 1'b0;
    end
    else
    begin
      commonClockGateOff     <= ctl_q[`UPC_BIT_CLOCK_OFF];
      commonTestSignalSelect <= ctl_q[`UPC_BIT_SIG_SELECT];
      crystalGainSelect      <= ctl_q[`UPC_BIT_XTAL_GAIN];
      // 24 MHz setting is passed through but not a valid operating mode
      pllReferenceSelect     <= ctl_q[`UPC_BIT_REF_SELECT];
      pllFastStartEnable     <= ctl_q[`UPC_BIT_FAST_START];
      usb2PllEnable          <= ctl_q[`UPC_BIT_PLL_ENABLE];
      // active low: zero overrides every per-port suspend
      commonSuspend_n        <= ctl_q[`UPC_BIT_COMMON_SUSP_N];
      crystalSuspend_n       <= ctl_q[`UPC_BIT_XTAL_SUSP_N];
      superspeedTxPllEnable  <= ctl_q[`UPC_BIT_SS_PLL_ENABLE];
      frontendReadyTimerOff  <= ctl_q[`UPC_BIT_TIMER_OFF];
      globalGatingBypass     <= ctl_q[`UPC_BIT_GATE_BYPASS];
    end
  end
endmodule // upc_common_test_regs

// three flops per pin; a change counts only when stages two and three agree
module upc_sync3
#(
  parameter STAGES = `UPC_SYNC_STAGES
)
(
  input  wire clock,
  input  wire reset,
  input  wire pinIn,
  output wire syncLevel,
  output wire syncRise
);
  reg [STAGES-1:0] chain_q;
  reg              level_q;
  reg              rise_q;

  assign syncLevel = level_q;
  assign syncRise  = rise_q;

  always @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      chain_q <= {STAGES{1'b0}};
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end
    else
    begin
      chain_q <= {chain_q[STAGES-2:0], pinIn};
      rise_q  <= 1'b0;
      if (chain_q[STAGES-1] == chain_q[STAGES-2])
      begin
        // a lone disagreeing sample is treated as settling noise
        level_q <= chain_q[STAGES-1];
        rise_q  <= chain_q[STAGES-1] & ~level_q;
      end
    end
  end
endmodule // upc_sync3

// >>> verification/upc_common_test_regs_asserts.sv
`timescale 1ns/1ns
module upc_common_test_regs_asserts
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ioSupplyReady,
  input wire logic        frontendTestWrite,
  input wire logic        frontendUpstreamWrite,
  input wire logic [31:0] frontendWriteData,
  input wire logic        commonClockGateOff,
  input wire logic        usb2PllEnable,
  input wire logic        globalGatingBypass
);
  wire logic hitCommon = paddr == 12'h200;
  wire logic mapped    = hitCommon || paddr == 12'h2C4 || paddr == 12'h2C8;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_err; pready |-> pslverr == !mapped; endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_err_only; pslverr |-> pready; endproperty
  a_err_only: assert property (p_err_only) else $error("error flag without answer");
  property p_resv; pready && !pwrite && hitCommon |-> (prdata & 32'h7E7021FE) == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
  property p_core; !ioSupplyReady [*6] ##0 (pready && !pwrite && hitCommon) |-> !prdata[18];
  endproperty
  a_core: assert property (p_core) else $error("core ready not gated");
  property p_outs; pready && pwrite && hitCommon && pstrb == 4'hF |=>
    commonClockGateOff == $past(pwdata[31]) && usb2PllEnable == $past(pwdata[16])
    && globalGatingBypass == $past(pwdata[0]); endproperty
  a_outs: assert property (p_outs) else $error("control pins do not follow write");
  property p_rst; $fell(reset) |-> usb2PllEnable && !commonClockGateOff && !globalGatingBypass;
  endproperty
  a_rst: assert property (p_rst) else $error("pin values wrong after reset");
  property p_fe; pready && pwrite && paddr == 12'h2C4 |->
    frontendTestWrite && frontendWriteData == pwdata; endproperty
  a_fe: assert property (p_fe) else $error("frontend write strobe missing");
  property p_fe_up; pready && pwrite && paddr == 12'h2C8 |->
    frontendUpstreamWrite && frontendWriteData == pwdata; endproperty
  a_fe_up: assert property (p_fe_up) else $error("upstream write strobe missing");
  property p_fe_only; frontendTestWrite || frontendUpstreamWrite |-> pready && pwrite;
  endproperty
  a_fe_only: assert property (p_fe_only) else $error("frontend strobe without write");
endmodule // upc_common_test_regs_asserts
bind upc_common_test_regs upc_common_test_regs_asserts u_chk
  (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
   .pslverr, .ioSupplyReady, .frontendTestWrite, .frontendUpstreamWrite, .frontendWriteData,
   .commonClockGateOff, .usb2PllEnable, .globalGatingBypass);

// >>> verification/tb_upc_common_test_regs.sv
`timescale 1ns/1ns
module tb_upc_common_test_regs;
  logic        clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [3:0]  pstrb = 0;
  logic        eepromPresent = 0, eepromFastStartHs = 0, eepromFastStartFs = 0;
  logic        highSpeedMode = 0, otpConfigured = 0, otpFastStart = 0;
  logic        usbReset = 0, liteReset = 0, coreSupplyReady = 0, ioSupplyReady = 0;
  logic        pllClockUsable = 0, ssClockUsable = 0;
  logic [31:0] frontendTestIn = 32'hA5A50F0F, frontendUpstreamIn = 32'h5A5AF0F0;
  wire  [31:0] prdata, frontendWriteData;
  wire         pready, pslverr, frontendTestWrite, frontendUpstreamWrite;
  wire         commonClockGateOff, commonTestSignalSelect, crystalGainSelect;
  wire         pllReferenceSelect, pllFastStartEnable, usb2PllEnable, commonSuspend_n;
  wire         crystalSuspend_n, superspeedTxPllEnable, frontendReadyTimerOff;
  wire         globalGatingBypass;
  wire  [10:0] pins = {commonClockGateOff, commonTestSignalSelect, crystalGainSelect,
    pllReferenceSelect, pllFastStartEnable, usb2PllEnable, commonSuspend_n,
    crystalSuspend_n, superspeedTxPllEnable, frontendReadyTimerOff, globalGatingBypass};
  int          n_mismatch = 0, tests_run = 0;
  upc_common_test_regs dut (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .eepromPresent, .eepromFastStartHs, .eepromFastStartFs,
    .highSpeedMode, .otpConfigured, .otpFastStart, .usbReset, .liteReset, .coreSupplyReady,
    .ioSupplyReady, .pllClockUsable, .ssClockUsable, .frontendTestIn, .frontendUpstreamIn,
    .commonClockGateOff, .commonTestSignalSelect, .crystalGainSelect, .pllReferenceSelect,
    .pllFastStartEnable, .usb2PllEnable, .commonSuspend_n, .crystalSuspend_n,
    .superspeedTxPllEnable, .frontendReadyTimerOff, .globalGatingBypass, .frontendTestWrite,
    .frontendUpstreamWrite, .frontendWriteData);
  always #5 clock = ~clock;
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // idle cycle between transfers keeps every strobe to one assignment per step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic err);
    int n;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    chk("pready", pready, 1);
    chk("pslverr", pslverr, err);
    psel <= 0; penable <= 0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(0, a, 0, 0, err);
    chk("rdata", rd, exp);
  endtask
  task t_boot(input logic ep, hs, fs, hsm, oc, of, ex);
    eepromPresent <= ep; eepromFastStartHs <= hs; eepromFastStartFs <= fs;
    highSpeedMode <= hsm; otpConfigured <= oc; otpFastStart <= of; reset <= 1;
    repeat (3) @(posedge clock);
    reset <= 0;
    repeat (2) @(posedge clock);
    rdc(12'h200, {14'h0, ex, 1'b1, 16'h0}, 0);
  endtask
  task t_write;
    apb(1, 12'h200, 32'hFFF7FFFF, 4'hF, 0); // reference select left at zero
    @(negedge clock);
    chk("pins", pins, 11'h77F);
    rdc(12'h200, 32'h8183CA01, 0);
    apb(1, 12'h200, 32'h0, 4'hF, 0);
    @(negedge clock);
    chk("pins", pins, 11'h0);
    apb(1, 12'h200, 32'hFFF7FFFF, 4'h2, 0);
    rdc(12'h200, 32'h0000CA00, 0);
  endtask
  task t_status;
    coreSupplyReady <= 1; pllClockUsable <= 1; ssClockUsable <= 1;
    repeat (8) @(posedge clock);
    rdc(12'h200, 32'h0000DE00, 0);
    ioSupplyReady <= 1;
    repeat (8) @(posedge clock);
    rdc(12'h200, 32'h0004DE00, 0);
    apb(1, 12'h200, 32'h00041400, 4'hF, 0);
    rdc(12'h200, 32'h00041400, 0);
  endtask
  task t_map;
    apb(1, 12'h400, 32'hFFFFFFFF, 4'hF, 1);
    rdc(12'h204, 32'h0, 1);
    apb(1, 12'h2C4, 32'h12345678, 4'hF, 0);
    apb(1, 12'h2C8, 32'h9ABCDEF0, 4'hF, 0);
    rdc(12'h2C4, 32'hA5A50F0F, 0);
    rdc(12'h2C8, 32'h5A5AF0F0, 0);
  endtask
  task t_reload;
    for (int i = 0; i < 2; i++)
    begin
      apb(1, 12'h200, 32'h0, 4'hF, 0);
      if (i == 0) usbReset <= 1; else liteReset <= 1;
      repeat (5) @(posedge clock);
      usbReset <= 0; liteReset <= 0;
      repeat (10) @(posedge clock);
      rdc(12'h200, 32'h00061400, 0);
    end
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    test_done;
  end
  initial
  begin
    repeat (3) @(posedge clock);
    t_boot(0, 0, 0, 0, 1, 1, 1);
    t_boot(0, 0, 0, 0, 0, 1, 0);
    t_boot(1, 0, 1, 1, 1, 1, 0);
    t_boot(1, 0, 1, 0, 0, 0, 1);
    t_boot(1, 1, 0, 1, 0, 0, 1);
    t_write;
    t_status;
    t_map;
    t_reload;
    test_done;
  end
endmodule // tb_upc_common_test_regs
